// ### common/iqi_pkg.sv
`default_nettype none
package iqi_pkg;

  // operation select codes
  localparam logic [1:0] MODE_QH_CHK = 2'h0;  // quad_head_insert_checked
  localparam logic [1:0] MODE_QH_RES = 2'h1;  // quad_head_insert_resident
  localparam logic [1:0] MODE_LT_CHK = 2'h2;  // long_tail_insert_checked

  // memory port operation codes
  localparam logic [2:0] MOP_LOCKED_LOAD = 3'h0;
  localparam logic [2:0] MOP_COND_STORE = 3'h1;
  localparam logic [2:0] MOP_BARRIER = 3'h2;
  localparam logic [2:0] MOP_WRITE = 3'h3;
  localparam logic [2:0] MOP_PROBE = 3'h4;

  // exception causes
  localparam logic [2:0] EXC_NONE = 3'h0;
  localparam logic [2:0] EXC_ILLEGAL_OPERAND = 3'h1;
  localparam logic [2:0] EXC_ACCESS_VIOLATION = 3'h2;
  localparam logic [2:0] EXC_FAULT_ON_READ = 3'h3;
  localparam logic [2:0] EXC_FAULT_ON_WRITE = 3'h4;
  localparam logic [2:0] EXC_TRANS_NOT_VALID = 3'h5;

  // result_status codes
  localparam logic [63:0] STATUS_EMPTY = 64'h0000_0000_0000_0001;
  localparam logic [63:0] STATUS_NOT_EMPTY = 64'h0000_0000_0000_0000;
  localparam logic [63:0] STATUS_INTERLOCKED = 64'hFFFF_FFFF_FFFF_FFFF;

  // link layout and interlock retry limit
  localparam logic [63:0] LOCK_BIT = 64'h0000_0000_0000_0001;
  localparam logic [63:0] QUAD_BACK_OFS = 64'h0000_0000_0000_0008;
  localparam logic [63:0] LONG_BACK_OFS = 64'h0000_0000_0000_0004;
  localparam logic [3:0] RETRY_LIMIT = 4'h8;

  typedef enum logic [3:0] {
    S_IDLE, S_LL, S_SC, S_MB1, S_CHK, S_PRB1, S_PRB2, S_RST,
    S_W1, S_W2, S_W3, S_W4, S_MB2, S_WFIN
  } iqi_state_t;

  typedef struct packed {
    iqi_state_t st;
    logic [1:0] mode;
    logic [3:0] retry;
    logic [63:0] hdr;
    logic [63:0] ent;
    logic [63:0] tmp0;
    logic [63:0] fwd;
    logic [2:0] cause;
    logic memReq;
    logic [2:0] memOp;
    logic [63:0] memAddr;
    logic [63:0] memWdata;
    logic memLong;
    logic done;
    logic [63:0] status;
    logic excValid;
    logic [2:0] excCause;
    logic busy;
  } iqi_regs_t;

endpackage
`default_nettype wire

// ### design/iqi_insert.sv
// How it works
// - quad head checked: misaligned low four bits or equal addresses give illegal operand
// - locked load header, test bit 0, conditional store with bit 0 set, count retries
// - lock already set or retries exhausted returns minus one, queue untouched
// - checked quad head: forward link bits 3:1 nonzero restores header, illegal operand
// - checked variants probe the entry, then the successor (quad) or predecessor (long); a fault restores header before queue changes
// - quad head writes entry forward, entry backward at 8, successor backward link
// - barrier after link updates, then header forward link written last, releasing lock
// - success returns one if queue was empty, else zero
// - whole insertion is non-interruptible between lock and release
// - secondary interlock excludes other processors' queue operations until released
// - long tail: low three bits, equal addresses or non-32-bit address give illegal operand
// - long tail sign-extends both links; bad link bits restore header and fault
// - long tail links entry, then predecessor forward if queue not empty, then header backward
// - long tail releases after barrier; status one when header points at new entry
// - checked variants report memory faults; resident variants report no exceptions at all
`timescale 1ns/1ps
`default_nettype none
module iqi_insert
  import iqi_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic startReq,
  input wire logic [1:0] opSel,
  input wire logic [63:0] headerAddressOperand,
  input wire logic [63:0] entryAddressOperand,
  output logic memReq,
  output logic [2:0] memOp,
  output logic [63:0] memAddr,
  output logic [63:0] memWdata,
  output logic memLong,
  input wire logic memAck,
  input wire logic [63:0] memRdata,
  input wire logic memScOk,
  input wire logic memFault,
  input wire logic [2:0] memFaultCause,
  output logic done,
  output logic [63:0] resultStatus,
  output logic excValid,
  output logic [2:0] excCause,
  output logic busy
);

  iqi_regs_t r_reg;
  iqi_regs_t r_next;

  // sign extension of a 32-bit link
  function automatic logic [63:0] sext32(input logic [31:0] v);
    sext32 = {{32{v[31]}}, v};
  endfunction

  logic isLong;
  logic checked;
  logic [63:0] diffQ;
  logic [63:0] t3;
  logic [63:0] lt1;
  logic [63:0] lt2;
  logic [63:0] quadSucc;
  logic [63:0] longPred;
  logic [63:0] hdrIn;
  logic [63:0] entIn;
  logic badOperand;
  logic memState;
  logic [2:0] reqOp;
  logic [63:0] reqAddr;
  logic [63:0] reqData;
  logic reqLong;

  // link arithmetic shared by the request and result decoders
  always_comb
  begin
    isLong = (r_reg.mode == MODE_LT_CHK);
    // only the two checked codes probe; code 3 runs unchecked like the resident variant
    checked = (r_reg.mode == MODE_QH_CHK) || (r_reg.mode == MODE_LT_CHK);
    diffQ = r_reg.hdr - r_reg.ent;
    t3 = sext32(diffQ[31:0]);
    lt1 = sext32(r_reg.tmp0[31:0]);
    lt2 = sext32(r_reg.tmp0[63:32]);
    quadSucc = r_reg.hdr + r_reg.tmp0;
    longPred = r_reg.hdr + lt2;
    hdrIn = headerAddressOperand;
    entIn = entryAddressOperand;
    // resident variant checks nothing, caller guarantees layout
    badOperand = 1'b0;
    if (opSel == MODE_QH_CHK)
    begin
      badOperand = (hdrIn[3:0] != 4'h0) || (entIn[3:0] != 4'h0) || (hdrIn == entIn);
    end
    else if (opSel == MODE_LT_CHK)
    begin
      badOperand = (hdrIn[2:0] != 3'h0) || (entIn[2:0] != 3'h0) || (hdrIn == entIn)
        || (sext32(hdrIn[31:0]) != hdrIn) || (sext32(entIn[31:0]) != entIn);
    end
  end

  // memory request selected by the current state
  always_comb
  begin
    memState = 1'b1;
    reqOp = MOP_WRITE;
    reqAddr = r_reg.hdr;
    reqData = 64'h0000_0000_0000_0000;
    reqLong = 1'b0;
    case (r_reg.st)
      S_LL: reqOp = MOP_LOCKED_LOAD;
      S_SC:
      begin
        reqOp = MOP_COND_STORE;
        reqData = r_reg.tmp0 | LOCK_BIT;
      end
      S_MB1, S_MB2: reqOp = MOP_BARRIER;
      S_PRB1:
      begin
        reqOp = MOP_PROBE;
        reqAddr = r_reg.ent;
      end
      S_PRB2:
      begin
        reqOp = MOP_PROBE;
        reqAddr = isLong ? longPred : quadSucc;
      end
      S_RST: reqData = r_reg.tmp0; // restore unlocked original header
      S_W1:
      begin
        reqAddr = r_reg.ent;
        reqData = isLong ? t3 : (r_reg.tmp0 + diffQ);
        reqLong = isLong;
      end
      S_W2:
      begin
        reqAddr = r_reg.ent + (isLong ? LONG_BACK_OFS : QUAD_BACK_OFS);
        reqData = isLong ? (lt2 + t3) : diffQ;
        reqLong = isLong;
      end
      S_W3:
      begin
        reqAddr = isLong ? longPred : (quadSucc + QUAD_BACK_OFS);
        reqData = isLong ? (64'h0 - t3 - lt2) : (64'h0 - r_reg.tmp0 - diffQ);
        reqLong = isLong;
      end
      S_W4:
      begin
        reqAddr = r_reg.hdr + LONG_BACK_OFS;
        reqData = 64'h0 - t3;
        reqLong = 1'b1;
      end
      S_WFIN:
      begin
        // lock bit is clear in every computed link, so this write releases
        reqData = isLong ? r_reg.fwd : (64'h0 - diffQ);
        reqLong = isLong;
      end
      default: memState = 1'b0;
    endcase
  end

  // sequencer: one request held until acknowledged, then step on
  always_comb
  begin
    r_next = r_reg;
    r_next.done = 1'b0;
    r_next.excValid = 1'b0;
    case (r_reg.st)
      S_IDLE:
      begin
        if (startReq)
        begin
          r_next.mode = opSel;
          r_next.hdr = hdrIn;
          r_next.ent = entIn;
          r_next.retry = RETRY_LIMIT;
          r_next.cause = EXC_NONE;
          if (badOperand)
          begin
            // rejected before any memory access
            r_next.done = 1'b1;
            r_next.excValid = 1'b1;
            r_next.excCause = EXC_ILLEGAL_OPERAND;
          end
          else
          begin
            r_next.busy = 1'b1;
            r_next.st = S_LL;
          end
        end
      end
      S_CHK:
      begin
        if (isLong ? ((lt1[2:1] != 2'h0) || (lt2[2:0] != 3'h0))
                   : (r_reg.tmp0[3:1] != 3'h0))
        begin
          r_next.cause = EXC_ILLEGAL_OPERAND;
          r_next.st = S_RST;
        end
        else
        begin
          r_next.st = S_PRB1;
        end
      end
      default:
      begin
        if (memState && !r_reg.memReq)
        begin
          r_next.memReq = 1'b1;
          r_next.memOp = reqOp;
          r_next.memAddr = reqAddr;
          r_next.memWdata = reqData;
          r_next.memLong = reqLong;
        end
        else if (memState && memAck)
        begin
          r_next.memReq = 1'b0;
          case (r_reg.st)
            S_LL:
            begin
              r_next.tmp0 = memRdata;
              if (memRdata[0])
              begin
                // another processor holds the queue
                r_next.st = S_IDLE;
                r_next.done = 1'b1;
                r_next.busy = 1'b0;
                r_next.status = STATUS_INTERLOCKED;
              end
              else
              begin
                r_next.st = S_SC;
              end
            end
            S_SC:
            begin
              r_next.retry = r_reg.retry - 4'h1;
              if (memScOk)
              begin
                r_next.st = S_MB1;
              end
              else if (r_reg.retry == 4'h1)
              begin
                r_next.st = S_IDLE;
                r_next.done = 1'b1;
                r_next.busy = 1'b0;
                r_next.status = STATUS_INTERLOCKED;
              end
              else
              begin
                r_next.st = S_LL;
              end
            end
            S_MB1:
            begin
              r_next.fwd = lt1;
              r_next.st = checked ? S_CHK : S_W1;
            end
            S_PRB1, S_PRB2:
            begin
              if (memFault)
              begin
                r_next.cause = memFaultCause;
                r_next.st = S_RST;
              end
              else
              begin
                r_next.st = (r_reg.st == S_PRB1) ? S_PRB2 : S_W1;
              end
            end
            S_RST:
            begin
              r_next.st = S_IDLE;
              r_next.done = 1'b1;
              r_next.excValid = 1'b1;
              r_next.excCause = r_reg.cause;
              r_next.busy = 1'b0;
            end
            S_W1: r_next.st = S_W2;
            S_W2:
            begin
              if (!isLong || (lt2 != 64'h0))
              begin
                r_next.st = S_W3;
              end
              else
              begin
                // empty queue: header forward link will name the entry
                r_next.fwd = sext32(32'h0 - t3[31:0]);
                r_next.st = S_W4;
              end
            end
            S_W3: r_next.st = isLong ? S_W4 : S_MB2;
            S_W4: r_next.st = S_MB2;
            S_MB2: r_next.st = S_WFIN;
            S_WFIN:
            begin
              r_next.st = S_IDLE;
              r_next.done = 1'b1;
              r_next.busy = 1'b0;
              if (isLong)
              begin
                r_next.status = (r_reg.fwd == (64'h0 - t3)) ? STATUS_EMPTY : STATUS_NOT_EMPTY;
              end
              else
              begin
                r_next.status = (r_reg.tmp0 == 64'h0) ? STATUS_EMPTY : STATUS_NOT_EMPTY;
              end
            end
            default: r_next.st = S_IDLE;
          endcase
        end
      end
    endcase
  end

  // state register; reset drops any pending request
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      r_reg <= '0;
    end
    else
    begin
      r_reg <= r_next;
    end
  end

  assign memReq = r_reg.memReq;
  assign memOp = r_reg.memOp;
  assign memAddr = r_reg.memAddr;
  assign memWdata = r_reg.memWdata;
  assign memLong = r_reg.memLong;
  assign done = r_reg.done;
  assign resultStatus = r_reg.status;
  assign excValid = r_reg.excValid;
  assign excCause = r_reg.excCause;
  assign busy = r_reg.busy;

endmodule // iqi_insert
`default_nettype wire

// ### tb/iqi_insert_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module iqi_insert_assertions
  import iqi_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic startReq,
  input wire logic [1:0] opSel,
  input wire logic [63:0] headerAddressOperand,
  input wire logic [63:0] entryAddressOperand,
  input wire logic memReq,
  input wire logic [2:0] memOp,
  input wire logic [63:0] memAddr,
  input wire logic [63:0] memWdata,
  input wire logic memAck,
  input wire logic [63:0] memRdata,
  input wire logic done,
  input wire logic [63:0] resultStatus,
  input wire logic excValid,
  input wire logic [2:0] excCause,
  input wire logic busy
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  logic go;
  logic [63:0] h;
  logic [63:0] e;
  logic [63:0] hdrSeen;
  // accepted start and its operands
  assign go = startReq && !busy;
  assign h = headerAddressOperand;
  assign e = entryAddressOperand;
  // header of the running op, so interlock traffic can be tied to it
  always_ff @(posedge mclk)
  begin
    if (go)
      hdrSeen <= h;
  end
  a_quad_bad_op: assert property (
    go && opSel == MODE_QH_CHK && (h[3:0] != 4'h0 || e[3:0] != 4'h0 || h == e)
    |=> done && excValid && excCause == EXC_ILLEGAL_OPERAND && !memReq)
    else $error("quad operand not refused");
  a_long_bad_op: assert property (
    go && opSel == MODE_LT_CHK && (h[2:0] != 3'h0 || e[2:0] != 3'h0 || h == e
    || h[63:31] != {33{h[31]}} || e[63:31] != {33{e[31]}})
    |=> done && excValid && excCause == EXC_ILLEGAL_OPERAND && !memReq)
    else $error("long operand not refused");
  a_lock_seen: assert property (
    memReq && memAck && memOp == MOP_LOCKED_LOAD && memRdata[0]
    |-> ##[1:4] (done && !excValid && resultStatus == STATUS_INTERLOCKED))
    else $error("set interlock not reported");
  a_lock_header: assert property (
    memReq && (memOp == MOP_LOCKED_LOAD || memOp == MOP_COND_STORE)
    |-> memAddr == hdrSeen && (memOp != MOP_COND_STORE || memWdata[0]))
    else $error("interlock access wrong");
  a_req_hold: assert property (
    memReq && !memAck |=> memReq && $stable(memOp) && $stable(memAddr) && $stable(memWdata))
    else $error("request changed before ack");
  a_req_drop: assert property (memReq && memAck |=> !memReq)
    else $error("request held after ack");
  a_mem_in_op: assert property (memReq |-> busy)
    else $error("memory access outside operation");
  a_busy_end: assert property ($fell(busy) |-> done)
    else $error("operation ended without completion");
endmodule  // iqi_insert_assertions
bind iqi_insert iqi_insert_assertions i_chk (
  .mclk(mclk), .rst(rst), .startReq(startReq), .opSel(opSel),
  .headerAddressOperand(headerAddressOperand), .entryAddressOperand(entryAddressOperand),
  .memReq(memReq), .memOp(memOp), .memAddr(memAddr), .memWdata(memWdata),
  .memAck(memAck), .memRdata(memRdata), .done(done), .resultStatus(resultStatus),
  .excValid(excValid), .excCause(excCause), .busy(busy)
);
`default_nettype wire

// ### tb/iqi_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module iqi_mem_model
  import iqi_pkg::*;
(
  input wire logic mclk,
  input wire logic memReq,
  input wire logic [2:0] memOp,
  input wire logic [63:0] memAddr,
  input wire logic [63:0] memWdata,
  input wire logic memLong,
  output logic memAck = 1'b0,
  output logic [63:0] memRdata = 64'h0,
  output logic memScOk = 1'b0,
  output logic memFault = 1'b0,
  output logic [2:0] memFaultCause = 3'h0
);
  logic [63:0] mem [logic [63:0]];  // sparse, whole queue always resident
  logic [63:0] wlog [$];  // writes in order, all ones marks a barrier
  int scFails = 0;  // stores spoilt by another processor
  int lag = 0;  // wait states per access
  logic probeBad = 1'b0;
  logic [2:0] badCause = EXC_ACCESS_VIOLATION;
  int cnt = 0;
  function automatic logic [63:0] rd(input logic [63:0] a);
    return mem.exists(a) ? mem[a] : 64'h0;
  endfunction
  // one access at a time; idle data lines toggle so nothing stale is read
  always @(posedge mclk)
  begin
    memAck <= 1'b0;
    memRdata <= ~memRdata;
    memScOk <= 1'b0;
    memFault <= 1'b0;
    if (memReq && !memAck && cnt < lag)
      cnt <= cnt + 1;
    else if (memReq && !memAck)
    begin
      cnt <= 0;
      memAck <= 1'b1;
      case (memOp)
        MOP_LOCKED_LOAD: memRdata <= rd(memAddr);
        MOP_COND_STORE:
          if (scFails > 0)
            scFails <= scFails - 1;
          else
          begin
            memScOk <= 1'b1;
            mem[memAddr] = memWdata;
          end
        MOP_BARRIER: wlog.push_back('1);
        MOP_PROBE:
        begin
          memFault <= probeBad;
          memFaultCause <= badCause;
        end
        default:
        begin
          wlog.push_back(memAddr);
          if (memLong)
            mem[memAddr] = rd(memAddr) & 64'hFFFF_FFFF_0000_0000 | 64'(memWdata[31:0]);
          else
            mem[memAddr] = memWdata;
        end
      endcase
    end
  end
endmodule  // iqi_mem_model
`default_nettype wire

// ### tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import iqi_pkg::*;
;
  logic mclk = 1'b0;
  logic rst;
  logic startReq;
  logic [1:0] opSel;
  logic [63:0] headerAddressOperand;
  logic [63:0] entryAddressOperand;
  logic memReq, memLong, memAck, memScOk, memFault, done, excValid, busy, ev;
  logic [2:0] memOp, memFaultCause, excCause, ec;
  logic [63:0] memAddr, memWdata, memRdata, resultStatus, st;
  int n_mismatch = 0;
  int check_count = 0;
  always #25 mclk = ~mclk;
  iqi_insert i_dut (
    .mclk(mclk), .rst(rst), .startReq(startReq), .opSel(opSel),
    .headerAddressOperand(headerAddressOperand), .entryAddressOperand(entryAddressOperand),
    .memReq(memReq), .memOp(memOp), .memAddr(memAddr), .memWdata(memWdata),
    .memLong(memLong), .memAck(memAck), .memRdata(memRdata), .memScOk(memScOk),
    .memFault(memFault), .memFaultCause(memFaultCause), .done(done),
    .resultStatus(resultStatus), .excValid(excValid), .excCause(excCause), .busy(busy)
  );
  iqi_mem_model i_mem (
    .mclk(mclk), .memReq(memReq), .memOp(memOp), .memAddr(memAddr),
    .memWdata(memWdata), .memLong(memLong), .memAck(memAck), .memRdata(memRdata),
    .memScOk(memScOk), .memFault(memFault), .memFaultCause(memFaultCause)
  );
  task automatic chk_val(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  // exp of zero means a clean completion
  task automatic chk_exc(input logic [2:0] exp);
    check_count++;
    if (ev !== (exp != 3'h0) || (exp != 3'h0 && ec !== exp))
    begin
      n_mismatch++;
      $display("[ERR] %0t exception %b cause %h", $time, ev, ec);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // one operation, start given off the sampling edge, bounded wait
  task automatic run_op(input logic [1:0] m, input logic [63:0] h, input logic [63:0] e);
    int n;
    @(negedge mclk);
    i_mem.wlog.delete();
    opSel = m;
    headerAddressOperand = h;
    entryAddressOperand = e;
    startReq = 1'b1;
    n = 0;
    do
    begin
      @(negedge mclk);
      startReq = 1'b0;
      n++;
    end
    while (done !== 1'b1 && n < 2000);
    // a hung operation is a mismatch in its own right
    if (done !== 1'b1)
    begin
      n_mismatch++;
      $display("[ERR] %0t operation never completed", $time);
    end
    st = resultStatus;
    ev = excValid;
    ec = excCause;
  endtask
  task automatic t_bad_ops();
    logic [1:0] md [4] = '{MODE_QH_CHK, MODE_QH_CHK, MODE_LT_CHK, MODE_LT_CHK};
    logic [63:0] ha [4] = '{64'h1008, 64'h1000, 64'h1004, 64'h1_0000_0000};
    logic [63:0] ea [4] = '{64'h2000, 64'h1000, 64'h2000, 64'h2000};
    for (int i = 0; i < 4; i++)
    begin
      run_op(md[i], ha[i], ea[i]);
      chk_exc(EXC_ILLEGAL_OPERAND);
    end
  endtask
  // empty queue on slow memory; barriers show in the write log
  task automatic t_quad_empty();
    logic [63:0] ex [6] = '{'1, 64'h2000, 64'h2008, 64'h1008, '1, 64'h1000};
    i_mem.mem.delete();
    i_mem.lag = 3;
    run_op(MODE_QH_RES, 64'h1000, 64'h2000);
    i_mem.lag = 0;
    chk_val(st, STATUS_EMPTY);
    for (int i = 0; i < 6; i++)
      chk_val(i_mem.wlog[i], ex[i]);
    chk_val(i_mem.rd(64'h2000), 64'hFFFF_FFFF_FFFF_F000);
    chk_val(i_mem.rd(64'h2008), 64'hFFFF_FFFF_FFFF_F000);
    chk_val(i_mem.rd(64'h1008), 64'h1000);
    chk_val(i_mem.rd(64'h1000), 64'h1000);
  endtask
  // one entry queued, two conditional stores lost to contention
  task automatic t_quad_queued();
    i_mem.mem.delete();
    i_mem.mem[64'h1000] = 64'h2000;
    i_mem.scFails = 2;
    run_op(MODE_QH_CHK, 64'h1000, 64'h5000);
    chk_val(64'(i_mem.scFails), 64'h0);
    chk_val(st, STATUS_NOT_EMPTY);
    chk_val(i_mem.rd(64'h5000), 64'hFFFF_FFFF_FFFF_E000);
    chk_val(i_mem.rd(64'h5008), 64'hFFFF_FFFF_FFFF_C000);
    chk_val(i_mem.rd(64'h3008), 64'h2000);
    chk_val(i_mem.rd(64'h1000), 64'h4000);
  endtask
  task automatic t_refused();
    i_mem.mem.delete();
    i_mem.mem[64'h1000] = 64'h2001;
    run_op(MODE_QH_RES, 64'h1000, 64'h5000);
    chk_val(st, STATUS_INTERLOCKED);
    chk_val(64'(i_mem.wlog.size()), 64'h0);
    i_mem.mem[64'h1000] = 64'h0;
    i_mem.scFails = int'(RETRY_LIMIT);
    run_op(MODE_LT_CHK, 64'h1000, 64'h5000);
    chk_val(st, STATUS_INTERLOCKED);
    chk_val(i_mem.rd(64'h1000), 64'h0);
  endtask
  task automatic t_faults();
    i_mem.mem.delete();
    i_mem.mem[64'h1000] = 64'h2002;
    run_op(MODE_QH_CHK, 64'h1000, 64'h5000);
    chk_exc(EXC_ILLEGAL_OPERAND);
    chk_val(i_mem.rd(64'h1000), 64'h2002);
    i_mem.mem[64'h1000] = 64'h1_0000_0000;
    run_op(MODE_LT_CHK, 64'h1000, 64'h2000);
    chk_exc(EXC_ILLEGAL_OPERAND);
    chk_val(i_mem.rd(64'h1000), 64'h1_0000_0000);
    i_mem.probeBad = 1'b1;
    for (logic [2:0] c = EXC_ACCESS_VIOLATION; c <= EXC_TRANS_NOT_VALID; c++)
    begin
      i_mem.badCause = c;
      i_mem.mem[64'h1000] = 64'h0;
      run_op(MODE_QH_CHK, 64'h1000, 64'h5000);
      chk_exc(c);
      chk_val(i_mem.rd(64'h1000) | i_mem.rd(64'h5000), 64'h0);
    end
    // unchecked codes never probe, so a bad probe cannot fault them
    i_mem.mem[64'h1000] = 64'h0;
    run_op(MODE_QH_RES, 64'h1000, 64'h5000);
    chk_exc(EXC_NONE);
    chk_val(st, STATUS_EMPTY);
    i_mem.mem[64'h1000] = 64'h0;
    run_op(2'h3, 64'h1000, 64'h5000);
    chk_exc(EXC_NONE);
    i_mem.probeBad = 1'b0;
  endtask
  task automatic t_long_empty();
    i_mem.mem.delete();
    run_op(MODE_LT_CHK, 64'h1000, 64'h2000);
    chk_val(st, STATUS_EMPTY);
    chk_val(i_mem.rd(64'h2000) & 64'hFFFF_FFFF, 64'hFFFF_F000);
    chk_val(i_mem.rd(64'h2004) & 64'hFFFF_FFFF, 64'hFFFF_F000);
    chk_val(i_mem.rd(64'h1004) & 64'hFFFF_FFFF, 64'h1000);
    chk_val(i_mem.rd(64'h1000) & 64'hFFFF_FFFF, 64'h1000);
  endtask
  // main sequence after 21 reset cycles
  initial
  begin
    rst = 1'b1;
    startReq = 1'b0;
    opSel = 2'h0;
    headerAddressOperand = 64'h0;
    entryAddressOperand = 64'h0;
    repeat (21) @(negedge mclk);
    rst = 1'b0;
    t_bad_ops();
    t_quad_empty();
    t_quad_queued();
    t_refused();
    t_faults();
    t_long_empty();
    report_and_stop();
  end
  // watchdog well past the few hundred cycles the sequence needs
  initial
  begin
    #1_000_000;
    n_mismatch++;
    $display("[ERR] %0t watchdog expired", $time);
    report_and_stop();
  end
endmodule  // tb_top
`default_nettype wire
